/* File: verilog/cie_pkg.sv */
// Behaviour
// - jump loads target into program counter, two cycles, flags untouched
// - memory-to-accumulator copy leaves all flags unchanged
// - immediate copy loads literal into accumulator, flags unchanged
// - accumulator-to-memory copy writes addressed byte, flags unchanged
// - no-operation changes nothing and advances to next instruction
// - or forms accumulator or operand, result to acc or memory, zero only
// - subroutine exit pops program counter from stack, flags untouched
// - subroutine exit with literal also loads literal into accumulator
// - interrupt exit pops program counter and sets global interrupt enable
// - pending interrupt is serviced before main program resumes after interrupt exit
// - rotate left moves old bit 7 into bit 0, carry not involved
// - rotate left through carry: old carry into bit 0, bit 7 to carry
// - rotate right moves old bit 0 into bit 7
// - rotate right through carry: old carry into bit 7, bit 0 to carry
// - rotate to accumulator forms write acc and leave memory untouched
// - subtract borrow: acc minus memory minus inverted carry, sets overflow zero half carry carry
// - after subtract carry is 0 on negative, 1 on zero or positive
// - memory form of subtract borrow writes difference back to memory
// - decrement-skip stores byte minus 1, skips next when zero, flags untouched
// - taken decrement-skip takes two cycles with a dummy cycle
// - skips take two cycles when taken, one when not; pc writes take two
package cie_pkg;
  localparam int PC_W     = 11;
  localparam int ADDR_W   = 7;
  localparam int DATA_W   = 8;
  localparam int MEM_DEPTH = 128;
  localparam int STACK_DEPTH = 4;
  localparam int SP_W     = 2;
  localparam int FLAG_W   = 4;

  // ---------------------------------------------------------------
  // flag positions and reset values
  // ---------------------------------------------------------------
  localparam int FLAG_C   = 0;
  localparam int FLAG_HC  = 1;
  localparam int FLAG_Z   = 2;
  localparam int FLAG_OVF = 3;
  localparam logic [PC_W-1:0]   PC_RESET    = 11'h000;
  localparam logic [PC_W-1:0]   IRQ_VECTOR  = 11'h004;
  localparam logic [DATA_W-1:0] ACC_RESET   = 8'h00;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 4'h0;
  localparam logic              GIE_RESET   = 1'b0;
  localparam logic [PC_W-1:0]   PC_STEP     = 11'h001;
  localparam logic [PC_W-1:0]   PC_SKIP     = 11'h002;

  // ---------------------------------------------------------------
  // instruction and alu codes
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    op_nop, op_jump_uncond, op_copy_mem_to_acc, op_copy_lit_to_acc, op_copy_acc_to_mem,
    op_or_mem, op_or_lit, op_or_into_memory, op_subroutine_exit, op_subroutine_exit_lit,
    op_interrupt_exit, op_rotate_left, op_rotate_left_to_acc, op_rotate_left_carry,
    op_rotate_left_carry_to_acc, op_rotate_right, op_rotate_right_to_acc,
    op_rotate_right_carry, op_rotate_right_carry_to_acc, op_subtract_borrow,
    op_subtract_borrow_to_memory, op_decrement_skip_zero
  } cie_op_t;

  typedef enum logic [2:0] {
    fn_or, fn_sub_borrow, fn_rol, fn_rol_c, fn_ror, fn_ror_c, fn_dec
  } cie_fn_t;
endpackage

/* File: verilog/cie_alu_if.sv */
`timescale 1ns/10ps
interface cie_alu_if;
  import cie_pkg::*;
  cie_fn_t           fn;
  logic [DATA_W-1:0] a;
  logic [DATA_W-1:0] m;
  logic              c_in;
  logic [DATA_W-1:0] res;
  logic              c_out;
  logic              hc_out;
  logic              z_out;
  logic              ovf_out;
  modport alu  (input fn, a, m, c_in, output res, c_out, hc_out, z_out, ovf_out);
  modport core (output fn, a, m, c_in, input res, c_out, hc_out, z_out, ovf_out);
endinterface

/* File: verilog/cie_alu.sv */
`timescale 1ns/10ps
module cie_alu
(
  cie_alu_if.alu bus
);
  import cie_pkg::*;

  logic [DATA_W:0] diff;
  logic [4:0]      nib;

  // ---------------------------------------------------------------
  // result and flag forming
  // ---------------------------------------------------------------
  always_comb
  begin
    // borrow in is the inverted carry
    diff = {1'b0, bus.a} - {1'b0, bus.m} - {8'h00, ~bus.c_in};
    nib  = {1'b0, bus.a[3:0]} - {1'b0, bus.m[3:0]} - {4'h0, ~bus.c_in};
    bus.res    = bus.a | bus.m;
    bus.c_out  = bus.c_in;
    bus.hc_out  = ~nib[4];
    bus.ovf_out = (bus.a[7] ^ bus.m[7]) & (bus.a[7] ^ diff[7]);
    unique case (bus.fn)
      fn_or:         bus.res = bus.a | bus.m;
      fn_sub_borrow:
      begin
        bus.res   = diff[DATA_W-1:0];
        bus.c_out = ~diff[DATA_W];
      end
      fn_rol:        bus.res = {bus.m[6:0], bus.m[7]};
      fn_rol_c:
      begin
        bus.res   = {bus.m[6:0], bus.c_in};
        bus.c_out = bus.m[7];
      end
      fn_ror:        bus.res = {bus.m[0], bus.m[7:1]};
      fn_ror_c:
      begin
        bus.res   = {bus.c_in, bus.m[7:1]};
        bus.c_out = bus.m[0];
      end
      fn_dec:        bus.res = bus.m - 8'h01;
    endcase
    bus.z_out = (bus.res == 8'h00);
  end
endmodule

/* File: verilog/cie_core.sv */
`timescale 1ns/10ps
module cie_core
(
  input  wire logic                       clock_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       instr_valid_i,
  input  wire cie_pkg::cie_op_t           instr_op_i,
  input  wire logic [cie_pkg::ADDR_W-1:0] instr_addr_i,
  input  wire logic [cie_pkg::DATA_W-1:0] instr_lit_i,
  input  wire logic [cie_pkg::PC_W-1:0]   instr_target_i,
  input  wire logic                       irq_pending_i,
  input  wire logic [cie_pkg::ADDR_W-1:0] dbg_addr_i,
  output logic                            instr_ready_o,
  output logic [cie_pkg::PC_W-1:0]        pc_o,
  output logic [cie_pkg::DATA_W-1:0]      acc_o,
  output logic [cie_pkg::FLAG_W-1:0]      flags_o,
  output logic                            global_irq_enable_o,
  output logic                            irq_ack_o,
  output logic [cie_pkg::DATA_W-1:0]      dbg_data_o
);
  import cie_pkg::*;

  typedef enum logic [1:0] {st_run, st_wait, st_irq} cie_state_t;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic cie_fn_t op_to_fn(input cie_op_t op);
    cie_fn_t f;
    f = fn_or;
    unique case (op)
      op_rotate_left, op_rotate_left_to_acc:             f = fn_rol;
      op_rotate_left_carry, op_rotate_left_carry_to_acc: f = fn_rol_c;
      op_rotate_right, op_rotate_right_to_acc:           f = fn_ror;
      op_rotate_right_carry, op_rotate_right_carry_to_acc: f = fn_ror_c;
      op_subtract_borrow, op_subtract_borrow_to_memory:  f = fn_sub_borrow;
      op_decrement_skip_zero:                            f = fn_dec;
      default:                                           f = fn_or;
    endcase
    return f;
  endfunction

  function automatic logic is_pop(input cie_op_t op);
    return (op == op_subroutine_exit) || (op == op_subroutine_exit_lit) ||
           (op == op_interrupt_exit);
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  cie_state_t        state_q;
  cie_state_t        state_d;
  logic              ready_q;
  logic              ready_d;
  logic [PC_W-1:0]   pc_q;
  logic [PC_W-1:0]   pc_d;
  logic [DATA_W-1:0] acc_q;
  logic [DATA_W-1:0] acc_d;
  logic [FLAG_W-1:0] flags_q;
  logic [FLAG_W-1:0] flags_d;
  logic              gie_q;
  logic              gie_d;
  logic              ack_q;
  logic              ack_d;
  logic [DATA_W-1:0] dbg_q;
  logic [PC_W-1:0]   stack_q [STACK_DEPTH];
  logic [SP_W-1:0]   sp_q;
  logic              push;
  logic              pop;
  logic [PC_W-1:0]   push_val;
  logic [PC_W-1:0]   stack_top;
  logic [DATA_W-1:0] mem_q [MEM_DEPTH];
  logic [DATA_W-1:0] mem_rd;
  logic              mem_we;
  logic [DATA_W-1:0] mem_wdata;
  logic              accept;
  logic              two_cyc;

  cie_alu_if alu_bus ();

  cie_alu u_alu
  (
    .bus (alu_bus.alu)
  );

  assign accept    = ready_q & instr_valid_i;
  assign mem_rd    = mem_q[instr_addr_i];
  assign stack_top = stack_q[sp_q - 2'd1];

  // ---------------------------------------------------------------
  // alu operand steering
  // ---------------------------------------------------------------
  always_comb
  begin
    alu_bus.fn   = op_to_fn(instr_op_i);
    alu_bus.a    = acc_q;
    alu_bus.c_in = flags_q[FLAG_C];
    // literal forms of or take the operand from the instruction
    if (instr_op_i == op_or_lit)
      alu_bus.m = instr_lit_i;
    else
      alu_bus.m = mem_rd;
  end

  // ---------------------------------------------------------------
  // execute
  // ---------------------------------------------------------------
  always_comb
  begin
    state_d   = state_q;
    pc_d      = pc_q;
    acc_d     = acc_q;
    flags_d   = flags_q;
    gie_d     = gie_q;
    ack_d     = 1'b0;
    mem_we    = 1'b0;
    mem_wdata = alu_bus.res;
    push      = 1'b0;
    pop       = 1'b0;
    push_val  = pc_q;
    two_cyc   = 1'b0;
    unique case (state_q)
      st_run:
      begin
        if (accept)
        begin
          pc_d = pc_q + PC_STEP;
          unique case (instr_op_i)
            op_nop:
            begin
            end
            op_jump_uncond:
            begin
              pc_d    = instr_target_i;
              two_cyc = 1'b1;
            end
            op_copy_mem_to_acc:  acc_d = mem_rd;
            op_copy_lit_to_acc:  acc_d = instr_lit_i;
            op_copy_acc_to_mem:
            begin
              mem_we    = 1'b1;
              mem_wdata = acc_q;
            end
            op_or_mem, op_or_lit:
            begin
              acc_d          = alu_bus.res;
              flags_d[FLAG_Z] = alu_bus.z_out;
            end
            op_or_into_memory:
            begin
              mem_we          = 1'b1;
              flags_d[FLAG_Z] = alu_bus.z_out;
            end
            op_subroutine_exit:
            begin
              pc_d    = stack_top;
              two_cyc = 1'b1;
            end
            op_subroutine_exit_lit:
            begin
              pc_d    = stack_top;
              acc_d   = instr_lit_i;
              two_cyc = 1'b1;
            end
            op_interrupt_exit:
            begin
              pc_d    = stack_top;
              gie_d   = 1'b1;
              two_cyc = 1'b1;
            end
            op_rotate_left, op_rotate_right:
              mem_we = 1'b1;
            op_rotate_left_to_acc, op_rotate_right_to_acc:
              acc_d = alu_bus.res;
            op_rotate_left_carry, op_rotate_right_carry:
            begin
              mem_we          = 1'b1;
              flags_d[FLAG_C] = alu_bus.c_out;
            end
            op_rotate_left_carry_to_acc, op_rotate_right_carry_to_acc:
            begin
              acc_d           = alu_bus.res;
              flags_d[FLAG_C] = alu_bus.c_out;
            end
            op_subtract_borrow, op_subtract_borrow_to_memory:
            begin
              if (instr_op_i == op_subtract_borrow_to_memory)
                mem_we = 1'b1;
              else
                acc_d = alu_bus.res;
              flags_d[FLAG_C]  = alu_bus.c_out;
              flags_d[FLAG_HC]  = alu_bus.hc_out;
              flags_d[FLAG_Z]   = alu_bus.z_out;
              flags_d[FLAG_OVF] = alu_bus.ovf_out;
            end
            op_decrement_skip_zero:
            begin
              mem_we = 1'b1;
              if (alu_bus.z_out)
              begin
                pc_d    = pc_q + PC_SKIP;
                two_cyc = 1'b1;
              end
            end
          endcase
          pop = is_pop(instr_op_i);
          // pc writes and taken skips insert one dummy cycle
          if (two_cyc)
            state_d = st_wait;
        end
      end
      st_wait:
        state_d = st_run;
      st_irq:
      begin
        // the held instruction was never taken, so pc_q is the return point
        push    = 1'b1;
        pc_d    = IRQ_VECTOR;
        gie_d   = 1'b0;
        ack_d   = 1'b1;
        state_d = st_wait;
      end
    endcase
    // interrupts are only taken at an instruction boundary
    if (state_d == st_run && gie_d && irq_pending_i)
      state_d = st_irq;
    ready_d = (state_d == st_run);
  end

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= st_run;
      ready_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      ready_q <= ready_d;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pc_q <= PC_RESET;
    else
      pc_q <= pc_d;
  end

  // ---------------------------------------------------------------
  // accumulator and flags
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      acc_q <= ACC_RESET;
    else
      acc_q <= acc_d;
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      flags_q <= FLAGS_RESET;
    else
      flags_q <= flags_d;
  end

  // ---------------------------------------------------------------
  // interrupt enable and entry
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      gie_q <= GIE_RESET;
      ack_q <= 1'b0;
    end
    else
    begin
      gie_q <= gie_d;
      ack_q <= ack_d;
    end
  end

  // ---------------------------------------------------------------
  // return stack
  // ---------------------------------------------------------------
  // no overflow detection: a fifth push silently overwrites the oldest
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sp_q <= '0;
      for (int i = 0; i < STACK_DEPTH; i++)
        stack_q[i] <= PC_RESET;
    end
    else if (push)
    begin
      stack_q[sp_q] <= push_val;
      sp_q          <= sp_q + 2'd1;
    end
    else if (pop)
      sp_q <= sp_q - 2'd1;
  end

  // ---------------------------------------------------------------
  // data memory
  // ---------------------------------------------------------------
  // no reset on the array so it can map to ram
  always_ff @(posedge clock_i)
  begin
    if (mem_we)
      mem_q[instr_addr_i] <= mem_wdata;
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      dbg_q <= 8'h00;
    else
      dbg_q <= mem_q[dbg_addr_i];
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign instr_ready_o       = ready_q;
  assign pc_o                = pc_q;
  assign acc_o               = acc_q;
  assign flags_o             = flags_q;
  assign global_irq_enable_o = gie_q;
  assign irq_ack_o           = ack_q;
  assign dbg_data_o          = dbg_q;
endmodule

/* File: tb/cie_core_monitor.sv */
`timescale 1ns/10ps
module cie_core_monitor
(
  input wire logic                       clock_i,
  input wire logic                       rst_n_i,
  input wire logic                       instr_valid_i,
  input wire cie_pkg::cie_op_t           instr_op_i,
  input wire logic [cie_pkg::DATA_W-1:0] instr_lit_i,
  input wire logic [cie_pkg::PC_W-1:0]   instr_target_i,
  input wire logic                       irq_pending_i,
  input wire logic                       instr_ready_o,
  input wire logic [cie_pkg::PC_W-1:0]   pc_o,
  input wire logic [cie_pkg::DATA_W-1:0] acc_o,
  input wire logic [cie_pkg::FLAG_W-1:0] flags_o,
  input wire logic                       global_irq_enable_o,
  input wire logic                       irq_ack_o
);
  import cie_pkg::*;
  logic tk;
  assign tk = instr_valid_i && instr_ready_o;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  flags_keep_a : assert property (tk && instr_op_i inside {op_nop, op_jump_uncond, op_copy_mem_to_acc,
    op_copy_lit_to_acc, op_copy_acc_to_mem, op_subroutine_exit, op_subroutine_exit_lit, op_interrupt_exit,
    op_rotate_left, op_rotate_left_to_acc, op_rotate_right, op_rotate_right_to_acc, op_decrement_skip_zero}
    |=> flags_o == $past(flags_o)) else $error("flags changed");
  carry_only_a : assert property (tk && instr_op_i inside {op_rotate_left_carry, op_rotate_left_carry_to_acc,
    op_rotate_right_carry, op_rotate_right_carry_to_acc} |=> flags_o[3:1] == $past(flags_o[3:1]))
    else $error("rotate touched other flags");
  jump_pc_a : assert property (tk && instr_op_i == op_jump_uncond
    |=> pc_o == $past(instr_target_i) && !instr_ready_o) else $error("jump target or gap wrong");
  exit_gap_a : assert property (tk && instr_op_i inside {op_subroutine_exit, op_subroutine_exit_lit,
    op_interrupt_exit} |=> !instr_ready_o) else $error("exit not two cycles");
  lit_acc_a : assert property (tk && instr_op_i inside {op_copy_lit_to_acc, op_subroutine_exit_lit}
    |=> acc_o == $past(instr_lit_i)) else $error("literal not in acc");
  or_lit_a : assert property (tk && instr_op_i == op_or_lit |=> acc_o == ($past(acc_o) | $past(instr_lit_i))
    && flags_o == {$past(flags_o[3]), acc_o == 8'h00, $past(flags_o[1:0])}) else $error("or literal wrong");
  nop_keep_a : assert property (tk && instr_op_i == op_nop
    |=> pc_o == $past(pc_o) + PC_STEP && acc_o == $past(acc_o)) else $error("nop changed state");
  irq_en_a : assert property (tk && instr_op_i == op_interrupt_exit |=> global_irq_enable_o)
    else $error("enable not set");
  pend_exit_a : assert property (tk && instr_op_i == op_interrupt_exit && irq_pending_i
    |=> ##[1:3] irq_ack_o) else $error("pending irq not taken");
  ack_vec_a : assert property (irq_ack_o |-> pc_o == IRQ_VECTOR && !global_irq_enable_o)
    else $error("irq entry wrong");
endmodule
bind cie_core cie_core_monitor cie_core_monitor_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .instr_valid_i(instr_valid_i), .instr_op_i(instr_op_i), .instr_lit_i(instr_lit_i),
  .instr_target_i(instr_target_i), .irq_pending_i(irq_pending_i), .instr_ready_o(instr_ready_o),
  .pc_o(pc_o), .acc_o(acc_o), .flags_o(flags_o), .global_irq_enable_o(global_irq_enable_o),
  .irq_ack_o(irq_ack_o));

/* File: tb/cie_core_tb.sv */
`timescale 1ns/10ps
module cie_core_tb;
  import cie_pkg::*;
  typedef struct {cie_op_t op; logic [7:0] a, m; logic c; logic [7:0] acc, mem; logic [3:0] mk, fl;} cie_row_t;
  logic        clock, rst_n, valid, pend, ready, irq_en, ack;
  cie_op_t     op;
  logic [6:0]  addr, dbg_addr;
  logic [7:0]  lit, acc, dbg_data, d;
  logic [10:0] tgt, pc, p0;
  logic [3:0]  flags, f0;
  int          error_cnt, checked, cycles;
  cie_row_t    r;
  cie_row_t    rows [20] = '{
    '{op_nop, 8'h5A, 8'h33, 1'b0, 8'h5A, 8'h33, 4'h0, 4'h0},
    '{op_copy_mem_to_acc, 8'h5A, 8'h33, 1'b1, 8'h33, 8'h33, 4'h0, 4'h0},
    '{op_copy_lit_to_acc, 8'h5A, 8'h33, 1'b0, 8'h33, 8'h33, 4'h0, 4'h0},
    '{op_copy_acc_to_mem, 8'h5A, 8'h33, 1'b1, 8'h5A, 8'h5A, 4'h0, 4'h0},
    '{op_or_mem, 8'h00, 8'h00, 1'b0, 8'h00, 8'h00, 4'h4, 4'h4},
    '{op_or_lit, 8'h50, 8'h0A, 1'b1, 8'h5A, 8'h0A, 4'h4, 4'h0},
    '{op_or_into_memory, 8'h50, 8'h0A, 1'b0, 8'h50, 8'h5A, 4'h4, 4'h0},
    '{op_rotate_left, 8'h11, 8'h81, 1'b0, 8'h11, 8'h03, 4'h0, 4'h0},
    '{op_rotate_left_to_acc, 8'h11, 8'h81, 1'b1, 8'h03, 8'h81, 4'h0, 4'h0},
    '{op_rotate_left_carry, 8'h11, 8'h81, 1'b0, 8'h11, 8'h02, 4'h1, 4'h1},
    '{op_rotate_left_carry_to_acc, 8'h11, 8'h40, 1'b1, 8'h81, 8'h40, 4'h1, 4'h0},
    '{op_rotate_right, 8'h11, 8'h81, 1'b1, 8'h11, 8'hC0, 4'h0, 4'h0},
    '{op_rotate_right_to_acc, 8'h11, 8'h01, 1'b0, 8'h80, 8'h01, 4'h0, 4'h0},
    '{op_rotate_right_carry, 8'h11, 8'h01, 1'b0, 8'h11, 8'h00, 4'h1, 4'h1},
    '{op_rotate_right_carry_to_acc, 8'h11, 8'h80, 1'b1, 8'hC0, 8'h80, 4'h1, 4'h0},
    '{op_subtract_borrow, 8'h10, 8'h01, 1'b1, 8'h0F, 8'h01, 4'hF, 4'h1},
    '{op_subtract_borrow, 8'h00, 8'h00, 1'b0, 8'hFF, 8'h00, 4'hF, 4'h0},
    '{op_subtract_borrow, 8'h80, 8'h01, 1'b1, 8'h7F, 8'h01, 4'hF, 4'h9},
    '{op_subtract_borrow_to_memory, 8'h05, 8'h05, 1'b1, 8'h05, 8'h00, 4'hF, 4'h7},
    '{op_decrement_skip_zero, 8'h11, 8'h05, 1'b1, 8'h11, 8'h04, 4'h0, 4'h0}};

  cie_core cie_core_inst (.clock_i(clock), .rst_n_i(rst_n), .instr_valid_i(valid), .instr_op_i(op),
    .instr_addr_i(addr), .instr_lit_i(lit), .instr_target_i(tgt), .irq_pending_i(pend), .dbg_addr_i(dbg_addr),
    .instr_ready_o(ready), .pc_o(pc), .acc_o(acc), .flags_o(flags), .global_irq_enable_o(irq_en),
    .irq_ack_o(ack), .dbg_data_o(dbg_data));

  always #4 clock = ~clock;
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task tick;
    @(posedge clock);
    #1;
  endtask
  task chk_v(input logic [10:0] g, input logic [10:0] e);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %0t value got %h exp %h", $time, g, e);
    end
  endtask
  task chk_b(input logic g, input logic e);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %0t flag got %b exp %b", $time, g, e);
    end
  endtask
  // spacing tick keeps valid from being lowered and raised in one step
  task issue(input cie_op_t o, input logic [7:0] l = 8'h00, input logic [6:0] a = 7'h05,
             input logic [10:0] t = 11'h000);
    tick;
    for (int n = 0; n < 20 && ready !== 1'b1; n++) tick;
    valid = 1'b1;
    op = o;
    lit = l;
    addr = a;
    tgt = t;
    tick;
    valid = 1'b0;
  endtask
  task rdm(input logic [6:0] a);
    dbg_addr = a;
    tick;
    d = dbg_data;
  endtask
  task wait_ack;
    for (int n = 0; n < 10 && ack !== 1'b1; n++) tick;
    chk_b(ack, 1'b1);
  endtask
  task enter(input logic [10:0] t);
    issue(op_interrupt_exit);
    chk_b(irq_en, 1'b1);
    issue(op_jump_uncond, 8'h00, 7'h05, t);
    pend = 1'b1;
    wait_ack;
    pend = 1'b0;
    chk_v(pc, IRQ_VECTOR);
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      print_verdict;
    end
  end
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial
  begin
    {clock, rst_n, valid, pend, addr, dbg_addr, lit, tgt} = '0;
    op = op_nop;
    repeat (2) @(posedge clock);
    #1 rst_n = 1'b1;
    foreach (rows[i])
    begin
      r = rows[i];
      issue(op_copy_lit_to_acc, r.m);
      issue(op_copy_acc_to_mem);
      issue(op_copy_lit_to_acc, {r.c, 7'h00});
      issue(op_copy_acc_to_mem, 8'h00, 7'h06);
      issue(op_rotate_left_carry_to_acc, 8'h00, 7'h06);
      issue(op_copy_lit_to_acc, r.a);
      f0 = flags;
      p0 = pc;
      issue(r.op, r.m);
      chk_v(acc, r.acc);
      chk_v(flags, (f0 & ~r.mk) | r.fl);
      chk_v(pc, p0 + PC_STEP);
      chk_b(ready, 1'b1);
      rdm(7'h05);
      chk_v(d, r.mem);
      $display("row %0d done", i);
    end
    issue(op_jump_uncond, 8'h00, 7'h05, 11'h7F3);
    chk_v(pc, 11'h7F3);
    chk_b(ready, 1'b0);
    tick;
    chk_b(ready, 1'b1);
    issue(op_copy_lit_to_acc, 8'h01);
    issue(op_copy_acc_to_mem);
    p0 = pc;
    issue(op_decrement_skip_zero);
    chk_v(pc, p0 + PC_SKIP);
    chk_b(ready, 1'b0);
    rdm(7'h05);
    chk_v(d, 8'h00);
    chk_b(ready, 1'b1);
    $display("jump and skip done");
    enter(11'h100);
    tick;
    pend = 1'b1;
    issue(op_interrupt_exit);
    chk_v(pc, 11'h100);
    chk_b(irq_en, 1'b1);
    wait_ack;
    pend = 1'b0;
    chk_v(pc, IRQ_VECTOR);
    chk_b(irq_en, 1'b0);
    issue(op_subroutine_exit);
    chk_v(pc, 11'h100);
    chk_b(ready, 1'b0);
    enter(11'h200);
    issue(op_subroutine_exit_lit, 8'hA5);
    chk_v(pc, 11'h200);
    chk_v(acc, 8'hA5);
    $display("exits done");
    rst_n = 1'b0;
    #1;
    chk_v(pc, PC_RESET);
    chk_v(acc, ACC_RESET);
    chk_v(flags, FLAGS_RESET);
    chk_b(irq_en, GIE_RESET);
    chk_b(ready, 1'b0);
    tick;
    rst_n = 1'b1;
    issue(op_nop);
    chk_v(pc, PC_RESET + PC_STEP);
    $display("reset done");
    print_verdict;
  end
endmodule
